// File: bench/der_tc_model.sv
// Purpose: Three transfer controllers taking requests and reporting completions
// Assumes: One clock, rst_b active low
// Notes:   slow holds each controller busy five cycles instead of one
`timescale 1ns/1ns
module der_tc_model (
  input  logic        sys_clk,    // Clock
  input  logic        rst_b,      // Reset, active low
  input  logic        slow,       // Long transfers
  input  logic [2:0]  tcReqValid, // Request valid
  input  logic [17:0] tcReqChan,  // Request channel
  output logic [2:0]  tcReqReady, // Request accepted
  output logic [2:0]  tcDone,     // Completion pulse
  output logic [17:0] tcDoneChan  // Completed channel
);
  logic [2:0] waitCnt_reg [0:2];
  logic [5:0] chanHold_reg [0:2];
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      tcReqReady <= 3'h7;
      tcDone <= 3'h0;
      tcDoneChan <= 18'h0;
      for (int q = 0; q < 3; q++) waitCnt_reg[q] <= 3'h0;
    end
    else
      for (int q = 0; q < 3; q++)
      begin
        tcDone[q] <= 1'b0;
        // Channel field is only meaningful with the pulse
        tcDoneChan[6*q+:6] <= ~tcDoneChan[6*q+:6];
        if (tcReqValid[q] && tcReqReady[q])
        begin
          tcReqReady[q] <= 1'b0;
          waitCnt_reg[q] <= slow ? 3'h5 : 3'h1;
          chanHold_reg[q] <= tcReqChan[6*q+:6];
        end
        else if (waitCnt_reg[q] != 3'h0)
        begin
          waitCnt_reg[q] <= waitCnt_reg[q] - 3'h1;
          if (waitCnt_reg[q] == 3'h1)
          begin
            tcDone[q] <= 1'b1;
            tcDoneChan[6*q+:6] <= chanHold_reg[q];
            tcReqReady[q] <= 1'b1;
          end
        end
      end
endmodule // der_tc_model

// File: bench/der_top_chk.sv
// Purpose: Port assertions for the DMA event routing front end
// Assumes: One clock, rst_b active low
// Notes:   Bound to every der_top instance
`timescale 1ns/1ns
module der_top_chk (
  input logic        sys_clk,        // Clock
  input logic        rst_b,          // Reset, active low
  input logic [2:0]  tcReqValid,     // Request valid
  input logic [17:0] tcReqChan,      // Request channel
  input logic [2:0]  tcReqReady,     // Request accepted
  input logic [2:0]  tcDone,         // Completion pulse
  input logic [17:0] tcDoneChan,     // Completed channel
  input logic [2:0]  tcError,        // Controller error pulse
  input logic [63:0] region0Enable,  // Region 0 reporting
  input logic [2:0]  burstWrEn,      // Burst size write strobe
  input logic [7:0]  burstWrData,    // Burst size write data
  input logic [7:0]  burstSize0,     // Controller zero burst size
  input logic [7:0]  burstSize2,     // Controller two burst size
  input logic        compIntGlobal,  // Global completion pulse
  input logic        compIntRegion0, // Region 0 completion pulse
  input logic        compIntRegion1, // Region 1 completion pulse
  input logic [2:0]  errIntTc        // Per-controller error pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_err_tc_copy: assert property (errIntTc == $past(tcError))
    else $error("controller error pulse not one cycle late");
  a_comp_global: assert property (|tcDone |=> compIntGlobal)
    else $error("no global completion pulse");
  a_comp_quiet: assert property (!(|tcDone) |=>
    !(compIntGlobal || compIntRegion0 || compIntRegion1))
    else $error("completion pulse without a completion");
  a_region_zero: assert property (tcDone[0] && region0Enable[tcDoneChan[5:0]] |=>
    compIntRegion0)
    else $error("no region 0 completion pulse");
  a_burst_write: assert property (burstWrEn[0] |=> burstSize0 == $past(burstWrData))
    else $error("burst size 0 not written");
  a_burst_last: assert property (burstWrEn[2] |=> burstSize2 == $past(burstWrData))
    else $error("burst size 2 not written");
  a_burst_keep: assert property (!burstWrEn[0] |=> $stable(burstSize0))
    else $error("burst size 0 changed without a write");
  a_req_hold: assert property (tcReqValid[0] && !tcReqReady[0] |=>
    tcReqValid[0] && $stable(tcReqChan[5:0]))
    else $error("queue 0 request dropped before acceptance");
endmodule // der_top_chk

bind der_top der_top_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .tcReqValid(tcReqValid),
  .tcReqChan(tcReqChan), .tcReqReady(tcReqReady), .tcDone(tcDone), .tcDoneChan(tcDoneChan),
  .tcError(tcError), .region0Enable(region0Enable), .burstWrEn(burstWrEn),
  .burstWrData(burstWrData), .burstSize0(burstSize0), .burstSize2(burstSize2),
  .compIntGlobal(compIntGlobal), .compIntRegion0(compIntRegion0),
  .compIntRegion1(compIntRegion1), .errIntTc(errIntTc));

// File: bench/dma_event_routing_and_tc_config_bench.sv
// Purpose: Self-checking bench for the DMA event routing front end
// Assumes: Inputs change at the falling edge
// Notes:   Accepted requests are logged as {queue, channel}
`timescale 1ns/1ns
module dma_event_routing_and_tc_config_bench;
  logic sys_clk = 0, rst_b = 0, slow = 0;
  logic [63:0] evt = 0, chanEnable = '1, swTrigger = 0, region0Enable = 0, region1Enable = 0;
  logic [127:0] chanQueueSel = 0;
  logic [2:0] burstWrEn = 0, tcError = 0, tcReqValid, tcReqReady, tcDone, errIntTc;
  logic [7:0] burstWrData = 0, burstSize0, burstSize1, burstSize2;
  logic [17:0] tcReqChan, tcDoneChan;
  logic compIntGlobal, compIntRegion0, compIntRegion1, errIntGlobal;
  int num_errors = 0, checks = 0, cycles = 0, nComp = 0, nReg0 = 0, nReg1 = 0, nErrG = 0;
  logic [7:0] got [$];

  der_top dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .bsp0_tx_event(evt[2]), .bsp0_rx_event(evt[3]), .bsp1_tx_event(evt[4]),
    .bsp1_rx_event(evt[5]), .video_histogram_event(evt[6]), .video_statistics_event(evt[7]),
    .video_previewer_event(evt[8]), .video_resizer_event(evt[9]),
    .audio_tx_even_event(evt[10]), .audio_tx_odd_event(evt[11]), .audio_tx_event(evt[12]),
    .audio_rx_even_event(evt[13]), .audio_rx_odd_event(evt[14]), .audio_rx_event(evt[15]),
    .uart0_rx_event(evt[22]), .uart0_tx_event(evt[23]), .uart1_rx_event(evt[24]),
    .uart1_tx_event(evt[25]), .i2c_rx_event(evt[28]), .i2c_tx_event(evt[29]),
    .gpio_pin_irq(evt[39:32]), .gpio_bank_irq(evt[46:40]), .timer0_low_event(evt[48]),
    .timer0_high_event(evt[49]), .timer1_low_event(evt[50]), .timer1_high_event(evt[51]),
    .pulse_out_event(evt[54:52]), .chanEnable(chanEnable), .swTrigger(swTrigger),
    .chanQueueSel(chanQueueSel), .region0Enable(region0Enable), .region1Enable(region1Enable),
    .burstWrEn(burstWrEn), .burstWrData(burstWrData), .tcReqValid(tcReqValid),
    .tcReqChan(tcReqChan), .tcReqReady(tcReqReady), .tcDone(tcDone), .tcDoneChan(tcDoneChan),
    .tcError(tcError), .burstSize0(burstSize0), .burstSize1(burstSize1),
    .burstSize2(burstSize2), .compIntGlobal(compIntGlobal), .compIntRegion0(compIntRegion0),
    .compIntRegion1(compIntRegion1), .errIntGlobal(errIntGlobal), .errIntTc(errIntTc));
  der_tc_model u_tc (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow), .tcReqValid(tcReqValid),
    .tcReqChan(tcReqChan), .tcReqReady(tcReqReady), .tcDone(tcDone), .tcDoneChan(tcDoneChan));

  // ==========================================================================
  // Clock, monitor and timeout
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    for (int q = 0; q < 3; q++)
      if (tcReqValid[q] === 1'b1 && tcReqReady[q] === 1'b1)
        got.push_back({q[1:0], tcReqChan[6*q+:6]});
    nComp += (compIntGlobal === 1'b1);
    nReg0 += (compIntRegion0 === 1'b1);
    nReg1 += (compIntRegion1 === 1'b1);
    nErrG += (errIntGlobal === 1'b1);
  end
  always @(posedge sys_clk)
    if (++cycles == 5000)
    begin
      num_errors++;
      end_of_test();
    end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic expect_req(input logic [7:0] exp);
    int n = 0;
    while (got.size() == 0 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (got.size() == 0) check(32'hFF, exp);
    else check(got.pop_front(), exp);
  endtask
  task automatic pulse(input logic [63:0] e, input logic [63:0] s);
    @(negedge sys_clk);
    evt = e;
    swTrigger = s;
    @(negedge sys_clk);
    evt = 64'h0;
    swTrigger = 64'h0;
  endtask
  function automatic bit mapped(input int c);
    return (c >= 2 && c <= 15) || (c >= 22 && c <= 25) || c == 28 || c == 29 ||
           (c >= 32 && c <= 46) || (c >= 48 && c <= 54);
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_burst;
    check({burstSize2, burstSize1, burstSize0}, 24'h402010);
    for (int q = 0; q < 3; q++)
    begin
      @(negedge sys_clk);
      burstWrEn = 3'h1 << q;
      burstWrData = 8'hA0 + q;
      @(negedge sys_clk);
      burstWrEn = 3'h0;
      check(({burstSize2, burstSize1, burstSize0} >> (8 * q)) & 24'hFF, 8'hA0 + q);
    end
  endtask
  task automatic t_routing;
    int nMapped = 0;
    for (int ch = 0; ch < 64; ch++)
    begin
      pulse(64'h1 << ch, 64'h0);
      if (mapped(ch))
      begin
        nMapped++;
        expect_req({2'h0, ch[5:0]});
      end
      else
      begin
        repeat (8) @(negedge sys_clk);
        check(got.size(), 0);
      end
    end
    // Every source at once, only unsourced channels enabled: nothing may trigger
    for (int ch = 0; ch < 64; ch++)
      chanEnable[ch] = !mapped(ch);
    pulse('1, 64'h0);
    repeat (8) @(negedge sys_clk);
    check(got.size(), 0);
    chanEnable = '1;
    repeat (4) @(negedge sys_clk);
    check(nComp, nMapped);
  endtask
  task automatic t_queues;
    chanQueueSel[61:60] = 2'h0;
    chanQueueSel[63:62] = 2'h1;
    chanQueueSel[95:94] = 2'h2;
    chanQueueSel[111:110] = 2'h3;
    pulse(64'h0, (64'h1 << 30) | (64'h1 << 31) | (64'h1 << 47) | (64'h1 << 55));
    expect_req(8'h1E);
    expect_req(8'h5F);
    expect_req(8'hAF);
    expect_req(8'hB7);
    chanEnable[3] = 1'b0;
    pulse(64'h8, 64'h0);
    repeat (8) @(negedge sys_clk);
    check(got.size(), 0);
    pulse(64'h0, 64'h8);
    expect_req(8'h03);
    chanEnable[3] = 1'b1;
  endtask
  task automatic t_merge;
    int e0 = nErrG, r0 = nReg0, r1 = nReg1;
    slow = 1'b1;
    region0Enable[10] = 1'b1;
    region1Enable[11] = 1'b1;
    @(negedge sys_clk);
    swTrigger = (64'h1 << 10) | (64'h1 << 11);
    @(negedge sys_clk);
    swTrigger = 64'h1 << 11;
    @(negedge sys_clk);
    swTrigger = 64'h0;
    expect_req(8'h0A);
    expect_req(8'h0B);
    repeat (8) @(negedge sys_clk);
    check(nErrG - e0, 1);
    check(nReg0 - r0, 1);
    check(nReg1 - r1, 1);
    slow = 1'b0;
    for (int q = 0; q < 3; q++)
    begin
      @(negedge sys_clk);
      tcError = 3'h1 << q;
      @(negedge sys_clk);
      tcError = 3'h0;
      check(errIntTc, 3'h1 << q);
    end
  endtask

  task automatic end_of_test;
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    t_burst();
    t_routing();
    t_queues();
    t_merge();
    end_of_test();
  end
endmodule // dma_event_routing_and_tc_config_bench

// File: hdl/der_queue.v
// Purpose: One event queue holding channel numbers awaiting a transfer controller
// Assumes: Single clock, push ignored while full
// Notes:   Head entry is presented from a register
`timescale 1ns/1ns
module der_queue #(
  parameter WIDTH = 6,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             sys_clk,   // System clock
  input  wire             rst_b,     // Asynchronous reset, active low
  input  wire             pushValid, // Entry offered
  input  wire [WIDTH-1:0] pushData,  // Channel number offered
  output wire             full,      // No room for another entry
  output reg              headValid, // Head entry valid
  output reg  [WIDTH-1:0] headData,  // Head channel number
  input  wire             headTake   // Head consumed this cycle
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_reg;
  reg [AW-1:0]    rdPtr_reg;
  reg [AW:0]      count_reg;
  wire            doPush;
  wire            doLoad;

  assign full   = (count_reg == DEPTH[AW:0]);
  assign doPush = pushValid && !full;
  assign doLoad = (count_reg != {(AW+1){1'b0}}) && (!headValid || headTake);

  always @(posedge sys_clk)
  begin
    if (doPush)
      mem[wrPtr_reg] <= pushData;
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      headValid <= 1'b0;
      headData  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (doPush)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (doLoad)
      begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
        headData  <= mem[rdPtr_reg];
        headValid <= 1'b1;
      end
      else if (headTake)
        headValid <= 1'b0;
      count_reg <= count_reg + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doLoad};
    end
  end

endmodule // der_queue

// File: hdl/der_regs.vh
// Purpose: Constants for the DMA event routing and transfer controller front end
// Assumes: Plain Verilog-2005, included by bare name
// Notes:   Definitions only
//
// Summary of operation
// - Sixty-four channels, each triggered and queued independently of the others.
// - Three event queues feed three transfer controllers, one queue per controller.
// - Default burst sizes programmable, resetting to 16, 32 and 64 bytes.
// - Completion interrupts: one global plus one each for shadow regions 0 and 1.
// - Error interrupts: one global channel error plus one per transfer controller.
// - Each sourced channel hard-wired to one event source (others have none); software enables which trigger.
// - Channels 2-5 serial ports, 6-9 video, 10-15 audio port events.
// - Channels 22-23 UART 0, 24-25 UART 1, 28-29 I2C receive then transmit.
// - Channels 32-39 GPIO pin interrupts, 40-46 GPIO bank interrupts 0 to 6.
// - Channels 48-51 timer low/high events, 52-54 pulse output events.
`ifndef DER_REGS_VH
`define DER_REGS_VH

// ==========================================================================
// Sizes
`define DER_NUM_CHAN      64
`define DER_CHAN_W        6
`define DER_NUM_QUEUE     3
`define DER_QSEL_W        2
`define DER_QUEUE_DEPTH   16
`define DER_QUEUE_AW      4
`define DER_BURST_W       8

// ==========================================================================
// Burst size reset values in bytes
`define DER_BURST0_RST    8'h10
`define DER_BURST1_RST    8'h20
`define DER_BURST2_RST    8'h40

// ==========================================================================
// Queue select codes
`define DER_QSEL_LAST     2'h2

// ==========================================================================
// First channel of each source group
`define DER_CH_BSP        2
`define DER_CH_VIDEO      6
`define DER_CH_AUDIO      10
`define DER_CH_UART0      22
`define DER_CH_UART1      24
`define DER_CH_I2C        28
`define DER_CH_GPIO_PIN   32
`define DER_CH_GPIO_BANK  40
`define DER_CH_TIMER      48
`define DER_CH_PWM        52

`endif

// File: hdl/der_top.v
// Purpose: Channel controller front end: event routing, queues, burst sizes, interrupts
// Assumes: All inputs synchronous to sys_clk; events are active-high levels
// Notes:   A channel triggers on the rising edge of its event while enabled
`timescale 1ns/1ns
`include "der_regs.vh"
module der_top (
  input  wire         sys_clk,              // System clock, 20 MHz
  input  wire         rst_b,                // Asynchronous reset, active low
  // Event sources
  input  wire         bsp0_tx_event,        // Serial port 0 transmit
  input  wire         bsp0_rx_event,        // Serial port 0 receive
  input  wire         bsp1_tx_event,        // Serial port 1 transmit
  input  wire         bsp1_rx_event,        // Serial port 1 receive
  input  wire         video_histogram_event,  // Video histogram
  input  wire         video_statistics_event, // Video statistics
  input  wire         video_previewer_event,  // Video previewer
  input  wire         video_resizer_event,    // Video resizer
  input  wire         audio_tx_even_event,  // Audio transmit even
  input  wire         audio_tx_odd_event,   // Audio transmit odd
  input  wire         audio_tx_event,       // Audio transmit
  input  wire         audio_rx_even_event,  // Audio receive even
  input  wire         audio_rx_odd_event,   // Audio receive odd
  input  wire         audio_rx_event,       // Audio receive
  input  wire         uart0_rx_event,       // UART 0 receive
  input  wire         uart0_tx_event,       // UART 0 transmit
  input  wire         uart1_rx_event,       // UART 1 receive
  input  wire         uart1_tx_event,       // UART 1 transmit
  input  wire         i2c_rx_event,         // I2C receive
  input  wire         i2c_tx_event,         // I2C transmit
  input  wire [7:0]   gpio_pin_irq,         // GPIO pin interrupts 0..7
  input  wire [6:0]   gpio_bank_irq,        // GPIO bank interrupts 0..6
  input  wire         timer0_low_event,     // Timer 0 low
  input  wire         timer0_high_event,    // Timer 0 high
  input  wire         timer1_low_event,     // Timer 1 low
  input  wire         timer1_high_event,    // Timer 1 high
  input  wire [2:0]   pulse_out_event,      // Pulse outputs 0..2
  // Software control
  input  wire [63:0]  chanEnable,           // Event trigger enable per channel
  input  wire [63:0]  swTrigger,            // Software trigger pulse per channel
  input  wire [127:0] chanQueueSel,         // Two-bit queue number per channel
  input  wire [63:0]  region0Enable,        // Channel reports to region 0
  input  wire [63:0]  region1Enable,        // Channel reports to region 1
  input  wire [2:0]   burstWrEn,            // Burst size write strobe per controller
  input  wire [7:0]   burstWrData,          // Burst size in bytes
  // Transfer controller side
  output wire [2:0]   tcReqValid,           // Request valid per controller
  output wire [17:0]  tcReqChan,            // Channel per controller, six bits each
  input  wire [2:0]   tcReqReady,           // Controller accepts request
  input  wire [2:0]   tcDone,               // Transfer complete pulse per controller
  input  wire [17:0]  tcDoneChan,           // Completed channel per controller
  input  wire [2:0]   tcError,              // Controller error pulse
  output reg  [7:0]   burstSize0,           // Controller zero burst size
  output reg  [7:0]   burstSize1,           // Controller one burst size
  output reg  [7:0]   burstSize2,           // Controller two burst size
  // Interrupts
  output reg          compIntGlobal,        // Global completion pulse
  output reg          compIntRegion0,       // Region 0 completion pulse
  output reg          compIntRegion1,       // Region 1 completion pulse
  output reg          errIntGlobal,         // Channel controller error pulse
  output reg  [2:0]   errIntTc              // Per-controller error pulse
);

  // ========================================================================
  // Event map
  reg  [63:0] eventRaw;
  reg  [63:0] eventPrev_reg;
  reg  [63:0] pending_reg;
  reg  [63:0] pending_next;
  reg  [63:0] newTrig;
  reg  [63:0] clearMask;
  reg  [2:0]  pushValid;
  reg  [17:0] pushChan;
  wire [2:0]  qFull;
  reg  [1:0]  sel;
  integer     i;
  integer     q;

  always @*
  begin
    eventRaw = 64'h0000000000000000;
    eventRaw[`DER_CH_BSP +: 4]   = {bsp1_rx_event, bsp1_tx_event,
                                    bsp0_rx_event, bsp0_tx_event};
    eventRaw[`DER_CH_VIDEO +: 4] = {video_resizer_event, video_previewer_event,
                                    video_statistics_event,
                                    video_histogram_event};
    eventRaw[`DER_CH_AUDIO +: 6] = {audio_rx_event, audio_rx_odd_event,
                                    audio_rx_even_event, audio_tx_event,
                                    audio_tx_odd_event,
                                    audio_tx_even_event};
    eventRaw[`DER_CH_UART0 +: 2] = {uart0_tx_event, uart0_rx_event};
    eventRaw[`DER_CH_UART1 +: 2] = {uart1_tx_event, uart1_rx_event};
    eventRaw[`DER_CH_I2C +: 2]   = {i2c_tx_event, i2c_rx_event};
    eventRaw[`DER_CH_GPIO_PIN +: 8]  = gpio_pin_irq;
    eventRaw[`DER_CH_GPIO_BANK +: 7] = gpio_bank_irq;
    eventRaw[`DER_CH_TIMER +: 4] = {timer1_high_event, timer1_low_event,
                                    timer0_high_event, timer0_low_event};
    eventRaw[`DER_CH_PWM +: 3]   = pulse_out_event;
  end

  // ========================================================================
  // Trigger and pending state
  always @*
  begin
    newTrig = (eventRaw & ~eventPrev_reg & chanEnable) | swTrigger;
  end

  // Lowest pending channel mapped to each queue is offered to it
  always @*
  begin
    pushValid = 3'b000;
    pushChan  = 18'h00000;
    clearMask = 64'h0000000000000000;
    sel       = 2'b00;
    for (q = 0; q < `DER_NUM_QUEUE; q = q + 1)
    begin
      for (i = `DER_NUM_CHAN - 1; i >= 0; i = i - 1)
      begin
        sel = chanQueueSel[i*2 +: 2];
        if (sel > `DER_QSEL_LAST)
          sel = `DER_QSEL_LAST;
        if (pending_reg[i] && (sel == q[1:0]))
        begin
          pushValid[q]       = 1'b1;
          pushChan[q*6 +: 6] = i[5:0];
        end
      end
      if (pushValid[q] && !qFull[q])
        clearMask[pushChan[q*6 +: 6]] = 1'b1;
    end
  end

  always @*
  begin
    pending_next = (pending_reg & ~clearMask) | newTrig;
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eventPrev_reg <= 64'h0000000000000000;
      pending_reg   <= 64'h0000000000000000;
    end
    else
    begin
      eventPrev_reg <= eventRaw;
      pending_reg   <= pending_next;
    end
  end

  // ========================================================================
  // Queues to transfer controllers
  genvar g;
  generate
    for (g = 0; g < `DER_NUM_QUEUE; g = g + 1)
    begin : gQueue
      der_queue #(
        .WIDTH (`DER_CHAN_W),
        .DEPTH (`DER_QUEUE_DEPTH),
        .AW    (`DER_QUEUE_AW)
      ) uQueue (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .pushValid (pushValid[g]),
        .pushData  (pushChan[g*6 +: 6]),
        .full      (qFull[g]),
        .headValid (tcReqValid[g]),
        .headData  (tcReqChan[g*6 +: 6]),
        .headTake  (tcReqReady[g] & tcReqValid[g])
      );
    end
  endgenerate

  // ========================================================================
  // Burst sizes
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      burstSize0 <= `DER_BURST0_RST;
      burstSize1 <= `DER_BURST1_RST;
      burstSize2 <= `DER_BURST2_RST;
    end
    else
    begin
      if (burstWrEn[0])
        burstSize0 <= burstWrData;
      if (burstWrEn[1])
        burstSize1 <= burstWrData;
      if (burstWrEn[2])
        burstSize2 <= burstWrData;
    end
  end

  // ========================================================================
  // Interrupt pulses
  reg     r0Hit;
  reg     r1Hit;
  integer k;

  always @*
  begin
    r0Hit = 1'b0;
    r1Hit = 1'b0;
    for (k = 0; k < `DER_NUM_QUEUE; k = k + 1)
    begin
      if (tcDone[k])
      begin
        if (region0Enable[tcDoneChan[k*6 +: 6]])
          r0Hit = 1'b1;
        if (region1Enable[tcDoneChan[k*6 +: 6]])
          r1Hit = 1'b1;
      end
    end
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      compIntGlobal  <= 1'b0;
      compIntRegion0 <= 1'b0;
      compIntRegion1 <= 1'b0;
      errIntGlobal   <= 1'b0;
      errIntTc       <= 3'b000;
    end
    else
    begin
      compIntGlobal  <= |tcDone;
      compIntRegion0 <= r0Hit;
      compIntRegion1 <= r1Hit;
      // Missed event: a channel triggered again while still pending
      errIntGlobal   <= |(newTrig & pending_reg & ~clearMask);
      errIntTc       <= tcError;
    end
  end

endmodule // der_top
